// ===== src/cbo_core.sv
`timescale 1ns/1ps
// Tail of the CPU execution unit: memory toggle, shifts, bit and flag ops
module cbo_core
  import cbo_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [BUS_AW-1:0] bus_addr,
  input wire logic [BUS_DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [BUS_DW-1:0] bus_rdata,
  output logic [MEM_AW-1:0] mem_addr,
  output logic [DW-1:0] mem_wdata,
  output logic mem_re,
  output logic mem_we,
  input wire logic [DW-1:0] mem_rdata,
  input wire logic mem_ext,
  input wire logic mem_ready,
  output logic [IO_AW-1:0] io_addr,
  output logic [2:0] io_bit,
  output logic io_set,
  output logic io_clr,
  output logic brk_pulse,
  output logic sleep_pulse,
  output logic wdr_pulse,
  output logic busy,
  output logic [DW-1:0] cpu_status_flags
);

  // Register file window hit
  function automatic logic rf_hit(input logic [BUS_AW-1:0] a);
    rf_hit = (a[7] == OFF_RF_BASE[7]) && (a[1:0] == 2'b00);
  endfunction

  // Register file window index
  function automatic logic [4:0] rf_idx(input logic [BUS_AW-1:0] a);
    rf_idx = a[6:2];
  endfunction

  // Ops that go through data memory
  function automatic logic is_mem(input cbo_op_t o);
    is_mem = (o == OP_LAT) || (o == OP_LDZ);
  endfunction

  // Flag index for set and clear forms
  function automatic logic [2:0] flag_sel(input cbo_op_t o, input logic [2:0] s);
    case (o)
      OP_SEV, OP_CLV: flag_sel = 3'(FLAG_V);
      OP_SEH, OP_CLH: flag_sel = 3'(FLAG_H);
      OP_SES, OP_CLS: flag_sel = 3'(FLAG_S);
      default: flag_sel = s;
    endcase
  endfunction

  // State
  cbo_state_t state_q, state_d; // Sequencer
  logic [BUS_DW-1:0] cmd_q; // Latched command word
  logic [DW-1:0] rf_q [RF_N]; // Register file
  logic [DW-1:0] flags_q, flags_d; // Status flags
  logic [BUS_DW-1:0] rdata_q; // Bus read data
  logic [MEM_AW-1:0] maddr_q; // Memory address
  logic [DW-1:0] mwdata_q; // Memory write data
  logic mre_q; // Memory read strobe
  logic mwe_q; // Memory write strobe
  logic [IO_AW-1:0] ioa_q; // I/O address
  logic [2:0] iob_q; // I/O bit
  logic ios_q; // I/O bit set strobe
  logic ioc_q; // I/O bit clear strobe
  logic brk_q; // Break pulse
  logic slp_q; // Sleep pulse
  logic wdr_q; // Watchdog reset pulse
  logic busy_q; // Busy indication
  logic ext_q; // Last access was external
  logic [7:0] cnt_q; // Busy cycle counter
  logic [7:0] last_cyc_q; // Cycles of last op

  // Outputs straight from flops
  assign bus_rdata = rdata_q;
  assign mem_addr = maddr_q;
  assign mem_wdata = mwdata_q;
  assign mem_re = mre_q;
  assign mem_we = mwe_q;
  assign io_addr = ioa_q;
  assign io_bit = iob_q;
  assign io_set = ios_q;
  assign io_clr = ioc_q;
  assign brk_pulse = brk_q;
  assign sleep_pulse = slp_q;
  assign wdr_pulse = wdr_q;
  assign busy = busy_q;
  assign cpu_status_flags = flags_q;

  // Command fields of the new and the latched word
  wire cbo_op_t new_op = cbo_op_t'(bus_wdata[CMD_OP_MSB:CMD_OP_LSB]);
  wire cbo_op_t op = cbo_op_t'(cmd_q[CMD_OP_MSB:CMD_OP_LSB]);
  wire [4:0] rd_i = cmd_q[CMD_RD_MSB:CMD_RD_LSB];
  wire [4:0] rr_i = cmd_q[CMD_RR_MSB:CMD_RR_LSB];
  wire [2:0] bsel = cmd_q[CMD_BIT_MSB:CMD_BIT_LSB];
  wire [4:0] nrd_i = bus_wdata[CMD_RD_MSB:CMD_RD_LSB];

  // Bus decode
  wire cmd_wr = bus_wr && (bus_addr == OFF_CMD);
  wire flg_wr = bus_wr && (bus_addr == OFF_FLAGS);
  wire rf_wr = bus_wr && rf_hit(bus_addr);
  wire take = cmd_wr && (state_q == ST_IDLE); // Ignored while busy

  // Completion points
  wire exec_done = state_q == ST_EXEC;
  // External memory may stretch the wait, internal never does
  wire mem_done = (state_q == ST_MEM_WAIT) && (!mem_ext || mem_ready);
  wire done = exec_done || mem_done;
  wire [MEM_AW-1:0] zptr = {rf_q[ZHI_IDX], rf_q[ZLO_IDX]};

  // Flag op decode
  wire [2:0] fsel = flag_sel(op, bsel);
  wire is_fset = (op == OP_GENERIC_FLAG_SET) || (op == OP_SEV) ||
                 (op == OP_SEH) || (op == OP_SES);
  wire is_fclr = (op == OP_GENERIC_FLAG_CLEAR) || (op == OP_CLV) ||
                 (op == OP_CLH) || (op == OP_CLS);

  // Shifter hookup
  cbo_alu_if alu_bus ();
  assign alu_bus.op = op;
  assign alu_bus.opa = (op == OP_BST) ? rf_q[rr_i] : rf_q[rd_i];
  assign alu_bus.bsel = bsel;
  assign alu_bus.flags_in = flags_q;

  cbo_alu u_alu (
    .alu(alu_bus)
  );

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = is_mem(new_op) ? ST_MEM_RD : ST_EXEC;
        end
      end
      ST_EXEC: state_d = ST_IDLE;
      ST_MEM_RD: state_d = ST_MEM_WAIT;
      ST_MEM_WAIT: begin
        if (mem_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Flag next value, instruction beats a bus write
  always_comb begin
    flags_d = flg_wr ? bus_wdata[DW-1:0] : flags_q;
    if (exec_done) begin
      if (is_fset) begin
        flags_d = flags_q;
        flags_d[fsel] = 1'b1;
      end else if (is_fclr) begin
        flags_d = flags_q;
        flags_d[fsel] = 1'b0;
      end else if (alu_bus.res_we || op == OP_BST) begin
        flags_d = alu_bus.flags_out;
      end
    end
  end

  // Read mux
  wire [BUS_DW-1:0] stat_w = {16'h0000, last_cyc_q, 6'h00, ext_q, busy_q};
  wire [BUS_DW-1:0] rmux =
    (bus_addr == OFF_CMD) ? cmd_q :
    (bus_addr == OFF_FLAGS) ? {24'h000000, flags_q} :
    (bus_addr == OFF_STAT) ? stat_w :
    rf_hit(bus_addr) ? {24'h000000, rf_q[rf_idx(bus_addr)]} : '0;

  // Sequencer and flags
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      flags_q <= FLAGS_RST;
    end else begin
      state_q <= state_d;
      flags_q <= flags_d;
    end
  end

  // Command latch and busy
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_q <= '0;
      busy_q <= 1'b0;
    end else begin
      if (take) begin
        cmd_q <= bus_wdata;
      end
      busy_q <= (state_d != ST_IDLE);
    end
  end

  // Busy cycle count, latched at completion
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= 8'h00;
      last_cyc_q <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      if (take) begin
        cnt_q <= 8'h01;
      end else if (!done && state_q != ST_IDLE) begin
        cnt_q <= cnt_q + 8'h01;
      end
      if (done) begin
        last_cyc_q <= cnt_q;
      end
      if (mem_done) begin
        ext_q <= mem_ext;
      end
    end
  end

  // Register file, instruction write beats bus write
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < RF_N; i++) begin
        rf_q[i] <= RF_RST;
      end
    end else begin
      if (rf_wr) begin
        rf_q[rf_idx(bus_addr)] <= bus_wdata[DW-1:0];
      end
      if (exec_done && alu_bus.res_we) begin
        rf_q[rd_i] <= alu_bus.res;
      end else if (mem_done) begin
        rf_q[rd_i] <= mem_rdata;
      end
    end
  end

  // Memory strobes: read at start, toggled byte written after
  always_ff @(posedge clock) begin
    if (rst) begin
      maddr_q <= '0;
      mwdata_q <= '0;
      mre_q <= 1'b0;
      mwe_q <= 1'b0;
    end else begin
      mre_q <= take && is_mem(new_op);
      mwe_q <= mem_done && (op == OP_LAT);
      if (take && is_mem(new_op)) begin
        maddr_q <= zptr;
      end
      if (mem_done && op == OP_LAT) begin
        mwdata_q <= rf_q[rd_i] ^ mem_rdata;
      end
    end
  end

  // I/O bit strobes and control pulses in the execute cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      ioa_q <= '0;
      iob_q <= 3'h0;
      ios_q <= 1'b0;
      ioc_q <= 1'b0;
      brk_q <= 1'b0;
      slp_q <= 1'b0;
      wdr_q <= 1'b0;
    end else begin
      if (take) begin
        ioa_q <= bus_wdata[CMD_IO_MSB:CMD_IO_LSB];
        iob_q <= bus_wdata[CMD_BIT_MSB:CMD_BIT_LSB];
      end
      ios_q <= take && (new_op == OP_SBI);
      ioc_q <= take && (new_op == OP_CBI);
      brk_q <= take && (new_op == OP_BRK);
      slp_q <= take && (new_op == OP_SLP);
      wdr_q <= take && (new_op == OP_WDR);
    end
  end

  // Read data stands one cycle only
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= bus_rd ? rmux : '0;
    end
  end

endmodule

// ===== src/cbo_pkg.sv
package cbo_pkg;
  // Behaviour
  // - Toggle memory byte at Z, return old, 2 cycles
  // - Rotate left through carry, flags ZCNVH, 1 cycle
  // - Rotate right through carry, flags ZCNV, 1 cycle
  // - Set I/O bit, no flags, 1 cycle
  // - Clear I/O bit, no flags, 1 cycle
  // - Copy register bit into T only
  // - Copy T into register bit, no flags
  // - Set overflow flag only, 1 cycle
  // - Clear overflow flag only, 1 cycle
  // - Set half carry flag only, 1 cycle
  // - Clear half carry flag only, 1 cycle
  // - Set sign flag only, 1 cycle
  // - Clear sign flag only, 1 cycle
  // - External memory accesses may take longer
  // - Internal SRAM load adds one cycle

  // Widths
  localparam int unsigned DW = 8;
  localparam int unsigned BUS_AW = 8;
  localparam int unsigned BUS_DW = 32;
  localparam int unsigned RF_N = 32;
  localparam int unsigned MEM_AW = 16;
  localparam int unsigned IO_AW = 6;
  // Register offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_RF_BASE = 8'h80;
  // Command word fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_OP_MSB = 4;
  localparam int unsigned CMD_RD_LSB = 5;
  localparam int unsigned CMD_RD_MSB = 9;
  localparam int unsigned CMD_RR_LSB = 10;
  localparam int unsigned CMD_RR_MSB = 14;
  localparam int unsigned CMD_BIT_LSB = 15;
  localparam int unsigned CMD_BIT_MSB = 17;
  localparam int unsigned CMD_IO_LSB = 18;
  localparam int unsigned CMD_IO_MSB = 23;
  // Status register fields
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_EXT = 1;
  localparam int unsigned STAT_CYC_LSB = 8;
  // Flag positions in cpu_status_flags
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] RF_RST = 8'h00;
  // Pointer Z lives in the top register pair
  localparam logic [4:0] ZLO_IDX = 5'h1e;
  localparam logic [4:0] ZHI_IDX = 5'h1f;
  // Busy cycles per instruction class
  localparam logic [7:0] CYC_SINGLE = 8'h01;
  localparam logic [7:0] CYC_LAT = 8'h02;
  localparam logic [7:0] CYC_LDZ_INT = 8'h02;

  // Operation codes
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BRK = 5'h01, OP_SLP = 5'h02, OP_WDR = 5'h03,
    OP_LAT = 5'h04, OP_LDZ = 5'h05, OP_LSL = 5'h06, OP_LSR = 5'h07,
    OP_ROL = 5'h08, OP_ROR = 5'h09, OP_ASR = 5'h0a, OP_SWAP = 5'h0b,
    OP_GENERIC_FLAG_SET = 5'h0c, OP_GENERIC_FLAG_CLEAR = 5'h0d, OP_SBI = 5'h0e, OP_CBI = 5'h0f,
    OP_BST = 5'h10, OP_BLD = 5'h11, OP_SEV = 5'h12, OP_CLV = 5'h13,
    OP_SEH = 5'h14, OP_CLH = 5'h15, OP_SES = 5'h16, OP_CLS = 5'h17
  } cbo_op_t;

  // Sequencer states, Gray along idle-read-wait
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_MEM_RD = 2'b01, ST_MEM_WAIT = 2'b11, ST_EXEC = 2'b10
  } cbo_state_t;
endpackage

// ===== src/cbo_alu_if.sv
`timescale 1ns/1ps
// Operand and result bundle between sequencer and shifter
interface cbo_alu_if;
  import cbo_pkg::*;
  cbo_op_t op; // Current operation
  logic [7:0] opa; // Register operand
  logic [2:0] bsel; // Bit index
  logic [7:0] flags_in; // Current flags
  logic [7:0] res; // Register result
  logic res_we; // Result goes to register
  logic [7:0] flags_out; // Flags after the op
  modport core (output op, output opa, output bsel, output flags_in,
                input res, input res_we, input flags_out);
  modport alu (input op, input opa, input bsel, input flags_in,
               output res, output res_we, output flags_out);
endinterface

// ===== src/cbo_alu.sv
`timescale 1ns/1ps
// Shift, rotate, swap and T-bit logic, purely combinational
module cbo_alu
  import cbo_pkg::*;
(
  cbo_alu_if.alu alu
);
  wire cin = alu.flags_in[FLAG_C]; // Carry in
  // Op class decode
  wire is_lsl = alu.op == OP_LSL;
  wire is_rol = alu.op == OP_ROL;
  wire is_lsr = alu.op == OP_LSR;
  wire is_ror = alu.op == OP_ROR;
  wire is_asr = alu.op == OP_ASR;
  wire is_left = is_lsl | is_rol;
  wire is_right = is_lsr | is_ror | is_asr;
  wire is_shift = is_left | is_right;
  wire is_swap = alu.op == OP_SWAP;
  wire is_bld = alu.op == OP_BLD;
  wire is_bst = alu.op == OP_BST;

  // Candidate results
  wire [7:0] r_lsl = {alu.opa[6:0], 1'b0};
  wire [7:0] r_rol = {alu.opa[6:0], cin};
  wire [7:0] r_lsr = {1'b0, alu.opa[7:1]};
  wire [7:0] r_ror = {cin, alu.opa[7:1]};
  wire [7:0] r_asr = {alu.opa[7], alu.opa[7:1]};
  wire [7:0] r_swp = {alu.opa[3:0], alu.opa[7:4]};
  wire [7:0] bmask = 8'h01 << alu.bsel; // Selected bit
  wire [7:0] r_bld = alu.flags_in[FLAG_T] ? (alu.opa | bmask)
                                          : (alu.opa & ~bmask);

  // Result selection
  assign alu.res = is_lsl ? r_lsl :
                   is_rol ? r_rol :
                   is_lsr ? r_lsr :
                   is_ror ? r_ror :
                   is_asr ? r_asr :
                   is_swap ? r_swp :
                   is_bld ? r_bld : alu.opa;
  assign alu.res_we = is_shift | is_swap | is_bld;

  // Shift flags: carry is the bit shifted out
  wire c_out = is_left ? alu.opa[7] : alu.opa[0];
  wire n_out = alu.res[7];
  wire z_out = alu.res == 8'h00;
  wire v_out = n_out ^ c_out;
  wire [7:0] f_shift;
  assign f_shift[FLAG_C] = c_out;
  assign f_shift[FLAG_Z] = z_out;
  assign f_shift[FLAG_N] = n_out;
  assign f_shift[FLAG_V] = v_out;
  assign f_shift[FLAG_S] = alu.flags_in[FLAG_S];
  // Half carry follows bit 3 on left moves only
  assign f_shift[FLAG_H] = is_left ? alu.opa[3] : alu.flags_in[FLAG_H];
  assign f_shift[FLAG_T] = alu.flags_in[FLAG_T];
  assign f_shift[FLAG_I] = alu.flags_in[FLAG_I];

  // T takes the selected register bit
  wire t_bst = |(alu.opa & bmask);
  wire [7:0] f_bst = (alu.flags_in & ~(8'h01 << FLAG_T)) |
                     ({7'h00, t_bst} << FLAG_T);

  // Flag selection, untouched for swap and bit load
  assign alu.flags_out = is_shift ? f_shift :
                         is_bst ? f_bst : alu.flags_in;
endmodule

// ===== sim/cbo_core_checker.sv
`timescale 1ns/1ps
// Port-level checks on the bit-op core
module cbo_core_checker
  import cbo_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [BUS_AW-1:0] bus_addr,
  input wire logic [BUS_DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [BUS_DW-1:0] bus_rdata,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic mem_ext,
  input wire logic mem_ready,
  input wire logic io_set,
  input wire logic io_clr,
  input wire logic busy,
  input wire logic [DW-1:0] cpu_status_flags
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Bit index field of a command word
  wire logic [2:0] cmd_bit = bus_wdata[17:15];
  // Accepted command with a given op code
  sequence cmd_issue(logic [4:0] op);
    bus_wr && bus_addr == OFF_CMD && !busy && bus_wdata[4:0] == op;
  endsequence
  // One busy cycle, then only the masked flag bits move
  property flag_op(logic [4:0] op, logic [7:0] s, logic [7:0] c);
    cmd_issue(op) |=> busy ##1
      (!busy && cpu_status_flags == (($past(cpu_status_flags) | s) & ~c));
  endproperty
  a_sev_only: assert property (flag_op(OP_SEV, 8'h08, 8'h00)) else $error("V set bad");
  a_clv_only: assert property (flag_op(OP_CLV, 8'h00, 8'h08)) else $error("V clr bad");
  a_seh_only: assert property (flag_op(OP_SEH, 8'h20, 8'h00)) else $error("H set bad");
  a_clh_only: assert property (flag_op(OP_CLH, 8'h00, 8'h20)) else $error("H clr bad");
  a_ses_only: assert property (flag_op(OP_SES, 8'h10, 8'h00)) else $error("S set bad");
  a_cls_only: assert property (flag_op(OP_CLS, 8'h00, 8'h10)) else $error("S clr bad");
  a_generic_set: assert property (cmd_issue(OP_GENERIC_FLAG_SET) |=> busy ##1
    (!busy && cpu_status_flags == ($past(cpu_status_flags) | (8'h01 << $past(cmd_bit, 2)))))
    else $error("generic set bad");
  a_io_set_once: assert property (io_set |-> busy ##1 (!io_set && !busy))
    else $error("io set not one cycle");
  a_io_clr_flags: assert property (io_clr |=> $stable(cpu_status_flags))
    else $error("io clear moved flags");
  a_mem_two_cyc: assert property (mem_re && !mem_ext |-> busy ##1 busy ##1 !busy)
    else $error("internal access not two cycles");
  a_ext_stretch: assert property (mem_re && mem_ext ##1 !mem_ready |=> busy)
    else $error("external wait not honoured");
  a_we_at_end: assert property ($rose(mem_we) |-> $fell(busy))
    else $error("write back misplaced");
  a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == '0)
    else $error("read data outside slot");
  // Main scenarios reached
  c_io_set: cover property (io_set);
  c_write_back: cover property (mem_we);
  c_ext_wait: cover property (mem_re && mem_ext ##1 busy ##1 busy ##1 busy);
endmodule

bind cbo_core cbo_core_checker u_chk (.clock(clock), .rst(rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .mem_re(mem_re), .mem_we(mem_we), .mem_ext(mem_ext), .mem_ready(mem_ready),
  .io_set(io_set), .io_clr(io_clr), .busy(busy), .cpu_status_flags(cpu_status_flags));

// ===== sim/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the bit-op core
module tb_top;
  import cbo_pkg::*;
  logic clock, rst, bus_wr, bus_rd, mem_ext, mem_ready, mem_re, mem_we;
  logic io_set, io_clr, brk_pulse, sleep_pulse, wdr_pulse, busy;
  logic [7:0] bus_addr, mem_wdata, mem_rdata, cpu_status_flags, mem_byte, pulse_cnt;
  logic [31:0] bus_wdata, bus_rdata;
  logic [15:0] mem_addr, we_addr;
  logic [7:0] we_data;
  logic [5:0] io_addr;
  logic [2:0] io_bit;
  logic [10:0] io_rec; // Last I/O strobe seen
  logic [1:0] rcnt; // External wait countdown
  logic [23:0] ex; // Expected shift result, flags and mask
  int miscompares, check_count, cyc_cnt, n, i;
  // Shift table: op, operand, carry in
  cbo_op_t to[7] = '{OP_ROL, OP_ROL, OP_ROR, OP_LSL, OP_LSR, OP_ASR, OP_SWAP};
  logic [7:0] tv[7] = '{8'h80, 8'h00, 8'h01, 8'h81, 8'h81, 8'h81, 8'h3c};
  logic tc[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  // Named flag ops and their bit
  cbo_op_t fo[6] = '{OP_SEV, OP_CLV, OP_SEH, OP_CLH, OP_SES, OP_CLS};
  logic [2:0] fb[6] = '{3'h3, 3'h3, 3'h5, 3'h5, 3'h4, 3'h4};

  cbo_core dut (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_we(mem_we), .mem_rdata(mem_rdata),
    .mem_ext(mem_ext), .mem_ready(mem_ready), .io_addr(io_addr), .io_bit(io_bit),
    .io_set(io_set), .io_clr(io_clr), .brk_pulse(brk_pulse), .sleep_pulse(sleep_pulse),
    .wdr_pulse(wdr_pulse), .busy(busy), .cpu_status_flags(cpu_status_flags));

  // Clock, 25 ns period
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Memory answer and watchers; data is garbage outside an access
  always @(posedge clock) begin
    mem_rdata <= (mem_re || busy) ? mem_byte : ~mem_rdata;
    if (rst) rcnt <= 2'd0;
    else rcnt <= mem_re ? 2'd2 : (rcnt != 2'd0 ? rcnt - 2'd1 : 2'd0);
    mem_ready <= (rcnt == 2'd1);
    if (mem_we) begin
      we_addr <= mem_addr;
      we_data <= mem_wdata;
    end
    if (io_set || io_clr) io_rec <= {io_set, io_clr, io_bit, io_addr};
    // Pulses are unknown until the first reset edge
    if (rst) pulse_cnt <= 8'h00;
    else pulse_cnt <= pulse_cnt + 8'(brk_pulse) + 8'(sleep_pulse) + 8'(wdr_pulse);
    cyc_cnt <= cyc_cnt + 1;
    // Hang guard
    if (cyc_cnt == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  // Read and compare; data stands in the following cycle
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask
  // Issue a command and count busy cycles
  task automatic exec(input logic [31:0] cmd);
    wr(OFF_CMD, cmd);
    n = 0;
    #1;
    while (busy === 1'b1 && n < 50) begin
      @(posedge clock);
      #1 n++;
    end
  endtask
  // Command word and register address
  function automatic logic [31:0] mk(logic [4:0] op, logic [4:0] rd, logic [4:0] rr,
                                     logic [2:0] b, logic [5:0] io);
    return {8'h00, io, b, rr, rd, op};
  endfunction
  function automatic logic [7:0] ra(logic [4:0] r);
    return {1'b1, r, 2'b00};
  endfunction
  // Expected result, flags and compare mask of a shift; S starts set
  function automatic logic [23:0] shx(cbo_op_t op, logic [7:0] v, logic c);
    logic [7:0] r;
    logic co;
    r = (op == OP_ROL) ? {v[6:0], c} : (op == OP_LSL) ? {v[6:0], 1'b0} :
        (op == OP_ROR) ? {c, v[7:1]} : (op == OP_LSR) ? {1'b0, v[7:1]} :
        (op == OP_ASR) ? {v[7], v[7:1]} : {v[3:0], v[7:4]};
    co = (op == OP_ROL || op == OP_LSL) ? v[7] : (op == OP_SWAP) ? c : v[0];
    if (op == OP_SWAP) return {r, 7'h08, c, 8'hff};
    return {r, 4'h1, r[7] ^ co, r[7], r == 8'h00, co,
            (op == OP_ROL || op == OP_LSL) ? 8'hdf : 8'hff};
  endfunction
  // One flag op from all-clear or all-set
  task automatic flag_case(input logic [4:0] op, input logic [2:0] b, input logic set);
    wr(OFF_FLAGS, set ? 32'h0 : 32'hff);
    exec(mk(op, 5'h0, 5'h0, b, 6'h0));
    chk(n, 1);
    rchk(OFF_FLAGS, {24'h0, set ? 8'h01 << b : ~(8'h01 << b)});
  endtask
  // Counts and verdict
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    mem_ext = 1'b0;
    mem_ready = 1'b0;
    mem_rdata = 8'h00;
    mem_byte = 8'hc3;
    rcnt = 2'd0;
    pulse_cnt = 8'h00;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    // Reset state and an unmapped place
    rchk(OFF_FLAGS, 32'h0);
    rchk(ra(5'd5), 32'h0);
    wr(8'h40, 32'hff);
    rchk(8'h40, 32'h0);
    // Toggle at Z, internal memory
    wr(ra(5'd30), 32'h34);
    wr(ra(5'd31), 32'h12);
    wr(ra(5'd16), 32'h5a);
    wr(OFF_FLAGS, 32'ha5);
    exec(mk(OP_LAT, 5'd16, 5'd0, 3'd0, 6'd0));
    chk(n, 2);
    rchk(ra(5'd16), 32'hc3);
    rchk(OFF_FLAGS, 32'ha5);
    chk({we_addr, we_data}, {8'h0, 16'h1234, 8'h99});
    // Load through Z, extra internal cycle
    exec(mk(OP_LDZ, 5'd17, 5'd0, 3'd0, 6'd0));
    chk(n, 2);
    rchk(ra(5'd17), 32'hc3);
    // External access stretches
    mem_byte = 8'h3c;
    @(posedge clock);
    mem_ext <= 1'b1;
    exec(mk(OP_LAT, 5'd16, 5'd0, 3'd0, 6'd0));
    chk(n > 2, 1);
    rchk(OFF_STAT, {16'h0, 8'(n), 8'h02});
    rchk(ra(5'd16), 32'h3c);
    chk(we_data, 32'hff);
    mem_ext <= 1'b0;
    // Shifts, rotates and swap
    for (i = 0; i < 7; i++) begin
      wr(OFF_FLAGS, {24'h0, 7'h08, tc[i]});
      wr(ra(5'd4), {24'h0, tv[i]});
      ex = shx(to[i], tv[i], tc[i]);
      exec(mk(to[i], 5'd4, 5'd0, 3'd0, 6'd0));
      chk(n, 1);
      rchk(ra(5'd4), {24'h0, ex[23:16]});
      @(posedge clock);
      #1 chk(cpu_status_flags & ex[7:0], ex[15:8]);
    end
    // Named and generic flag ops
    for (i = 0; i < 6; i++) flag_case(fo[i], fb[i], !i[0]);
    for (i = 0; i < 16; i++) flag_case(i[3] ? OP_GENERIC_FLAG_CLEAR : OP_GENERIC_FLAG_SET, i[2:0], !i[3]);
    // T flag moves
    wr(OFF_FLAGS, 32'h0);
    wr(ra(5'd8), 32'h20);
    wr(ra(5'd9), 32'h81);
    exec(mk(OP_BST, 5'd0, 5'd8, 3'd5, 6'd0));
    rchk(OFF_FLAGS, 32'h40);
    exec(mk(OP_BLD, 5'd9, 5'd0, 3'd2, 6'd0));
    chk(n, 1);
    rchk(ra(5'd9), 32'h85);
    rchk(OFF_FLAGS, 32'h40);
    exec(mk(OP_BST, 5'd0, 5'd8, 3'd4, 6'd0));
    rchk(OFF_FLAGS, 32'h0);
    // I/O bit set then clear
    exec(mk(OP_SBI, 5'd0, 5'd0, 3'd3, 6'h2a));
    chk(io_rec, {2'b10, 3'd3, 6'h2a});
    exec(mk(OP_CBI, 5'd0, 5'd0, 3'd7, 6'h3f));
    chk(io_rec, {2'b01, 3'd7, 6'h3f});
    rchk(OFF_FLAGS, 32'h0);
    // Control ops, one cycle each, one pulse each for BRK, SLP and WDR
    for (i = 0; i < 4; i++) begin
      exec(mk(i[4:0], 5'd0, 5'd0, 3'd0, 6'd0));
      chk(n, 1);
    end
    @(posedge clock);
    chk(pulse_cnt, 3);
    complete_run();
  end
endmodule
